// >>> hdl/fbp_params.svh
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

// array geometry: 256 KB as 32-bit words
`define FBP_WADDR_W 16
`define FBP_WORDS 65536
`define FBP_DATA_W 32
// 1 KB erase block = 256 words
`define FBP_BLK_W 8
`define FBP_BLK_LAST 8'hFF
`define FBP_BLK_FIRST 8'h00
// 2 KB protection unit = two erase blocks
`define FBP_UNIT_W 7
`define FBP_UNITS 128
`define FBP_UNIT_LSB 9
// erased and denied data values
`define FBP_ERASED 32'hFFFFFFFF
`define FBP_DENIED 32'h00000000
// erase length in cycles from request to done pulse
`define FBP_ERASE_CYC 257

`endif

// >>> hdl/fbp_pkg.sv
`default_nettype none
package fbp_pkg;
    // erase sequencer states, gray along idle -> erase -> idle
    typedef enum logic [0:0] {
        FBP_IDLE = 1'h0,
        FBP_ERASE = 1'h1
    } fbp_state_t;
endpackage
`default_nettype wire

// >>> hdl/fbp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbp_params.svh"

// Behaviour
// - 256 KB array, erased in independent 1 KB blocks.
// - a finished erase leaves every bit of the block at one.
// - protection is held per 2 KB unit of two blocks, units independent.
// - each unit can be marked read-only or execute-only.
// - read-only units refuse every erase and program.
// - execute-only units refuse every erase and program.
// - execute-only units answer instruction fetches only; data and debug reads denied.
// - permitted reads answer on the next clock, no wait states.
module fbp_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic if_req,
    input wire logic [`FBP_WADDR_W-1:0] if_addr,
    output logic if_valid,
    output logic [`FBP_DATA_W-1:0] if_rdata,
    input wire logic dr_req,
    input wire logic [`FBP_WADDR_W-1:0] dr_addr,
    output logic dr_valid,
    output logic dr_deny,
    output logic [`FBP_DATA_W-1:0] dr_rdata,
    input wire logic dbg_req,
    input wire logic [`FBP_WADDR_W-1:0] dbg_addr,
    output logic dbg_valid,
    output logic dbg_deny,
    output logic [`FBP_DATA_W-1:0] dbg_rdata,
    input wire logic pg_req,
    input wire logic [`FBP_WADDR_W-1:0] pg_addr,
    input wire logic [`FBP_DATA_W-1:0] pg_data,
    output logic pg_ack,
    output logic pg_deny,
    input wire logic er_req,
    input wire logic [`FBP_BLK_W-1:0] er_blk,
    output logic er_busy,
    output logic er_done,
    output logic er_deny,
    input wire logic pset_req,
    input wire logic [`FBP_UNIT_W-1:0] pset_unit,
    input wire logic pset_xo,
    output logic viol,
    input wire logic viol_clr
);

    ////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [`FBP_DATA_W-1:0] mem [`FBP_WORDS];
    logic [`FBP_UNITS-1:0] prot_ro;
    logic [`FBP_UNITS-1:0] prot_xo;
    fbp_pkg::fbp_state_t state;
    logic [`FBP_BLK_W-1:0] er_cur;
    logic [`FBP_BLK_W-1:0] er_cnt;

    // protection unit holding a word address
    function automatic logic [`FBP_UNIT_W-1:0] unit_of(input logic [`FBP_WADDR_W-1:0] a);
        unit_of = a[`FBP_WADDR_W-1:`FBP_UNIT_LSB];
    endfunction

    // unit accepts no erase or program when either mark is set
    function automatic logic locked(input logic [`FBP_UNIT_W-1:0] u, input logic [`FBP_UNITS-1:0] ro,
                                    input logic [`FBP_UNITS-1:0] xo);
        locked = ro[u] | xo[u];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // request decode
    wire idle = (state == fbp_pkg::FBP_IDLE);
    wire er_take = er_req && idle;
    wire er_ref = er_take && locked(er_blk[`FBP_BLK_W-1:1], prot_ro, prot_xo);
    wire er_go = er_take && !er_ref;
    wire pg_take = pg_req && idle;
    wire pg_ref = pg_take && locked(unit_of(pg_addr), prot_ro, prot_xo);
    wire pg_go = pg_take && !pg_ref;
    wire dr_ref = dr_req && prot_xo[unit_of(dr_addr)];
    wire dbg_ref = dbg_req && prot_xo[unit_of(dbg_addr)];
    wire any_ref = er_ref || pg_ref || dr_ref || dbg_ref;
    wire er_last = (er_cnt == `FBP_BLK_LAST);
    wire [`FBP_WADDR_W-1:0] er_waddr = {er_cur, er_cnt};
    wire [`FBP_WADDR_W-1:0] pg_waddr = pg_addr;
    wire [`FBP_DATA_W-1:0] pg_merged = mem[pg_waddr] & pg_data; // program only clears bits
    wire next_viol = any_ref || (viol && !viol_clr); // set wins over clear

    ////////////////////////////////////////////////////////////////////////
    // array writes: erase sweep or program, never both
    always_ff @(posedge sys_clk) begin
        if (!idle) begin
            mem[er_waddr] <= `FBP_ERASED; // only the selected block
        end else if (pg_go) begin
            mem[pg_waddr] <= pg_merged; // refused writes never reach here
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // erase sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= fbp_pkg::FBP_IDLE;
            er_cur <= `FBP_BLK_FIRST;
            er_cnt <= `FBP_BLK_FIRST;
        end else begin
            case (state)
                fbp_pkg::FBP_IDLE: begin
                    er_cnt <= `FBP_BLK_FIRST;
                    if (er_go) begin
                        er_cur <= er_blk;
                        state <= fbp_pkg::FBP_ERASE;
                    end
                end
                fbp_pkg::FBP_ERASE: begin
                    er_cnt <= er_cnt + 8'h01;
                    if (er_last) begin
                        state <= fbp_pkg::FBP_IDLE;
                    end
                end
                default: state <= fbp_pkg::FBP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection marks, set one unit at a time, held until reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prot_ro <= '0;
            prot_xo <= '0;
        end else if (pset_req) begin
            if (pset_xo) begin
                prot_xo[pset_unit] <= 1'b1;
            end else begin
                prot_ro[pset_unit] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read ports, answered on the next edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            if_valid <= 1'b0;
            if_rdata <= `FBP_DENIED;
            dr_valid <= 1'b0;
            dr_deny <= 1'b0;
            dr_rdata <= `FBP_DENIED;
            dbg_valid <= 1'b0;
            dbg_deny <= 1'b0;
            dbg_rdata <= `FBP_DENIED;
        end else begin
            if_valid <= if_req; // fetches pass any mark
            if_rdata <= if_req ? mem[if_addr] : `FBP_DENIED;
            dr_valid <= dr_req && !dr_ref;
            dr_deny <= dr_ref;
            dr_rdata <= (dr_req && !dr_ref) ? mem[dr_addr] : `FBP_DENIED;
            dbg_valid <= dbg_req && !dbg_ref;
            dbg_deny <= dbg_ref;
            dbg_rdata <= (dbg_req && !dbg_ref) ? mem[dbg_addr] : `FBP_DENIED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write answers and violation flag
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pg_ack <= 1'b0;
            pg_deny <= 1'b0;
            er_busy <= 1'b0;
            er_done <= 1'b0;
            er_deny <= 1'b0;
            viol <= 1'b0;
        end else begin
            pg_ack <= pg_go;
            pg_deny <= pg_ref;
            er_busy <= idle ? er_go : !er_last;
            er_done <= !idle && er_last;
            er_deny <= er_ref;
            viol <= next_viol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_erasing;
        ##1 er_busy [*8];
    endsequence
    sequence s_finish;
        ##249 !er_busy && er_done;
    endsequence

    erase_length_a: assert property (er_go |-> s_erasing ##0 s_finish)
        else $error("erase did not finish in 257 cycles");
    erase_ones_a: assert property (er_done |-> mem[{er_cur, `FBP_BLK_LAST}] == `FBP_ERASED
                                   && mem[{er_cur, `FBP_BLK_FIRST}] == `FBP_ERASED)
        else $error("erased block not all ones");
    unit_indep_a: assert property (pset_req && pset_unit != 7'h00 |=> $stable(prot_ro[0])
                                   && $stable(prot_xo[0]))
        else $error("mark leaked into another unit");
    mark_set_a: assert property (pset_req && pset_xo |=> prot_xo[$past(pset_unit)])
        else $error("execute-only mark not held");
    ro_noprog_a: assert property (pg_take && prot_ro[unit_of(pg_addr)] |=> pg_deny && !pg_ack)
        else $error("program accepted in read-only unit");
    xo_noerase_a: assert property (er_take && prot_xo[er_blk[`FBP_BLK_W-1:1]] |=> er_deny && !er_busy)
        else $error("erase accepted in execute-only unit");
    xo_dread_a: assert property (dr_req && prot_xo[unit_of(dr_addr)] |=> dr_deny && !dr_valid
                                 && dr_rdata == `FBP_DENIED)
        else $error("execute-only data leaked to data read");
    xo_fetch_a: assert property (if_req && !pg_go && idle |=> if_valid
                                 && if_rdata == mem[$past(if_addr)])
        else $error("fetch did not return contents");
    read_single_a: assert property (dbg_req && !prot_xo[unit_of(dbg_addr)] |=> dbg_valid && !dbg_deny)
        else $error("permitted debug read not answered next cycle");
    viol_sticky_a: assert property (any_ref |=> viol ##1 (viol || $past(viol_clr)))
        else $error("violation flag not raised or lost");
    prog_keep_a: assert property (pg_ref |=> mem[$past(pg_addr)] == $past(mem[pg_addr]))
        else $error("refused program changed contents");

endmodule

`default_nettype wire

// >>> sim/fbp_core_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbp_params.svh"

// instruction fetch side of the core, one fetch per go pulse
module fbp_core_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic fetch_go,
    input wire logic [`FBP_WADDR_W-1:0] fetch_word,
    output logic if_req,
    output logic [`FBP_WADDR_W-1:0] if_addr
);
    // idle address toggles so a stale value never looks valid
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            if_req <= 1'b0;
            if_addr <= 16'h0000;
        end else begin
            if_req <= fetch_go;
            if_addr <= fetch_go ? fetch_word : ~if_addr;
        end
    end
endmodule
`default_nettype wire

// >>> sim/fbp_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbp_params.svh"

module fbp_top_tb_top;
    logic sys_clk = 1'b0, nrst = 1'b0, fetch_go = 1'b0, dr_req = 1'b0, dbg_req = 1'b0, pg_req = 1'b0;
    logic er_req = 1'b0, pset_req = 1'b0, pset_xo = 1'b0, viol_clr = 1'b0;
    logic if_req, if_valid, dr_valid, dr_deny, dbg_valid, dbg_deny;
    logic pg_ack, pg_deny, er_busy, er_done, er_deny, viol;
    logic [`FBP_WADDR_W-1:0] fetch_word = 16'h0000, dr_addr = 16'h0000, dbg_addr = 16'h0000;
    logic [`FBP_WADDR_W-1:0] pg_addr = 16'h0000, if_addr;
    logic [`FBP_DATA_W-1:0] pg_data = 32'h00000000, if_rdata, dr_rdata, dbg_rdata;
    logic [`FBP_BLK_W-1:0] er_blk = 8'h00;
    logic [`FBP_UNIT_W-1:0] pset_unit = 7'h00;
    int n_fail = 0, checks_done = 0, cyc = 0;
    fbp_core_model core (.sys_clk, .nrst, .fetch_go, .fetch_word, .if_req, .if_addr);
    fbp_top dut (.sys_clk, .nrst, .if_req, .if_addr, .if_valid, .if_rdata, .dr_req, .dr_addr, .dr_valid,
        .dr_deny, .dr_rdata, .dbg_req, .dbg_addr, .dbg_valid, .dbg_deny, .dbg_rdata, .pg_req, .pg_addr,
        .pg_data, .pg_ack, .pg_deny, .er_req, .er_blk, .er_busy, .er_done, .er_deny, .pset_req,
        .pset_unit, .pset_xo, .viol, .viol_clr);
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // bus cycle tasks, each except mark checks its one-cycle answer
    task automatic rd(input logic use_dbg, input logic [15:0] a, input logic deny, input logic [31:0] d);
        @(posedge sys_clk);
        dr_req <= !use_dbg;
        dbg_req <= use_dbg;
        dr_addr <= a;
        dbg_addr <= a;
        @(posedge sys_clk);
        dr_req <= 1'b0;
        dbg_req <= 1'b0;
        #1;
        chk("read valid", {31'h0, !deny}, use_dbg ? dbg_valid : dr_valid);
        chk("read deny", {31'h0, deny}, use_dbg ? dbg_deny : dr_deny);
        chk("read data", d, use_dbg ? dbg_rdata : dr_rdata);
    endtask
    task automatic fetch(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        fetch_go <= 1'b1;
        fetch_word <= a;
        @(posedge sys_clk);
        fetch_go <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("fetch valid", 32'h1, if_valid);
        chk("fetch data", d, if_rdata);
    endtask
    task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic deny);
        @(posedge sys_clk);
        pg_req <= 1'b1;
        pg_addr <= a;
        pg_data <= d;
        @(posedge sys_clk);
        pg_req <= 1'b0;
        #1;
        chk("program ack", {31'h0, !deny}, pg_ack);
        chk("program deny", {31'h0, deny}, pg_deny);
    endtask
    task automatic erase(input logic [7:0] b, input logic deny);
        int n;
        @(posedge sys_clk);
        er_req <= 1'b1;
        er_blk <= b;
        @(posedge sys_clk);
        er_req <= 1'b0;
        #1;
        n = 0;
        chk("erase deny", {31'h0, deny}, er_deny);
        chk("erase busy", {31'h0, !deny}, er_busy);
        while (!deny && er_done !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (!deny) chk("erase length", `FBP_ERASE_CYC - 1, n);
        if (!deny) chk("erase end busy", 32'h0, er_busy);
    endtask
    task automatic mark(input logic [6:0] u, input logic xo);
        @(posedge sys_clk);
        pset_req <= 1'b1;
        pset_unit <= u;
        pset_xo <= xo;
        @(posedge sys_clk);
        pset_req <= 1'b0;
    endtask
    task automatic clear_viol();
        chk("viol set", 32'h1, viol);
        @(posedge sys_clk);
        viol_clr <= 1'b1;
        @(posedge sys_clk);
        viol_clr <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("viol clear", 32'h0, viol);
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_erase();
        erase(8'h03, 0);
        prog(16'h0310, 32'h12345678, 0);
        erase(8'h02, 0);
        rd(0, 16'h0200, 0, `FBP_ERASED);
        rd(1, 16'h02FF, 0, `FBP_ERASED);
        prog(16'h0310, 32'hF0F0F0F0, 0);
        rd(0, 16'h0310, 0, 32'h10305070);
        chk("viol idle", 32'h0, viol);
    endtask
    task automatic t_read_only();
        mark(7'h01, 0);
        erase(8'h03, 1);
        prog(16'h0200, 32'h0, 1);
        rd(0, 16'h0200, 0, `FBP_ERASED);
        rd(1, 16'h0310, 0, 32'h10305070);
        clear_viol();
        erase(8'h04, 0);
    endtask
    task automatic t_exec_only();
        erase(8'h00, 0);
        mark(7'h00, 1);
        fetch(16'h0005, `FBP_ERASED);
        rd(0, 16'h0005, 1, `FBP_DENIED);
        rd(1, 16'h00FF, 1, `FBP_DENIED);
        prog(16'h0005, 32'h0, 1);
        erase(8'h01, 1);
        fetch(16'h0005, `FBP_ERASED);
        clear_viol();
    endtask
    // denied read in the same cycle as a clear: the set must win
    task automatic t_viol_race();
        @(posedge sys_clk);
        viol_clr <= 1'b1;
        dr_req <= 1'b1;
        dr_addr <= 16'h0005;
        @(posedge sys_clk);
        viol_clr <= 1'b0;
        dr_req <= 1'b0;
        #1;
        chk("race deny", 32'h1, dr_deny);
        chk("viol race", 32'h1, viol);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        t_erase();
        t_read_only();
        t_exec_only();
        t_viol_race();
        finish_test();
    end
endmodule
`default_nettype wire
